//--- include/elb_pkg.sv
// shared constants and types of the event log buffer
package elb_pkg;
    localparam int unsigned ELB_DEPTH = 2000;
    localparam int unsigned ELB_IW = 11;
    typedef logic [ELB_IW-1:0] elb_idx_t;
    localparam elb_idx_t ELB_CAP_DEF = 11'h0C8;
    localparam elb_idx_t ELB_CAP_MIN = 11'h032;
    localparam elb_idx_t ELB_CAP_MAX = 11'h7D0;
    localparam logic [7:0] ELB_CTRL_OFS = 8'h00;
    localparam logic [7:0] ELB_CAP_OFS = 8'h04;
    localparam logic [7:0] ELB_COUNT_OFS = 8'h08;
    localparam logic [7:0] ELB_MASK_OFS = 8'h0C;
    localparam logic [7:0] ELB_POP_OFS = 8'h10;
    localparam logic [7:0] ELB_HCODE_OFS = 8'h14;
    localparam logic [7:0] ELB_HDATE_OFS = 8'h18;
    localparam logic [7:0] ELB_HTIME_OFS = 8'h1C;
    localparam logic [7:0] ELB_HFAULT_OFS = 8'h20;
    localparam logic [7:0] ELB_STAT_OFS = 8'h24;
    localparam logic [7:0] ELB_IEN_OFS = 8'h28;
    localparam logic [7:0] ELB_UNREAD_OFS = 8'h2C;
    localparam int unsigned ELB_CTRL_ORDER = 0;
    localparam int unsigned ELB_CTRL_SCALE = 1;
    localparam int unsigned ELB_CTRL_POPUP = 2;
    localparam int unsigned ELB_CTRL_CLEAR = 3;
    localparam logic [2:0] ELB_CTRL_RST = 3'h0;
    localparam logic [31:0] ELB_MASK_RST = 32'h0;
    localparam logic per_unit_scale = 1'b0;
    localparam int unsigned ELB_ST_LOGGED = 0;
    localparam int unsigned ELB_ST_OVF = 1;
    localparam logic [1:0] ELB_STAT_RST = 2'h0;
    localparam logic [1:0] ELB_RESP_OKAY = 2'h0;
    localparam logic [1:0] ELB_RESP_SLVERR = 2'h2;
    localparam logic [7:0] ELB_MASKED_STAGES = 8'h08;
    typedef enum logic [1:0]
    {
        ELB_START_ON = 2'h0,
        ELB_START_OFF = 2'h1,
        ELB_TRIP_ON = 2'h2,
        ELB_TRIP_OFF = 2'h3
    } elb_kind_e;
    typedef struct packed
    {
        logic [11:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
        logic [9:0] msec;
    } elb_stamp_s;
    typedef struct packed
    {
        logic overflow_marker;
        logic fault_value_scaling;
        logic [7:0] event_channel_number;
        logic [7:0] channel_event_number;
        elb_stamp_s stamp;
        logic [15:0] fault;
    } elb_entry_s;
endpackage

//--- rtl/elb_entry_mem.sv
// flip-flop entry store with one write port and two read ports
`timescale 1ns/100ps
module elb_entry_mem
    import elb_pkg::*;
(
    input wire logic aclk,
    input wire logic wr_en,
    input wire elb_idx_t wr_idx,
    input wire elb_entry_s wr_data,
    input wire elb_idx_t rd_idx_a,
    output elb_entry_s rd_data_a,
    input wire elb_idx_t rd_idx_b,
    output elb_entry_s rd_data_b
);
    elb_entry_s mem_q [ELB_DEPTH];

    genvar g;
    generate
        for (g = 0; g < ELB_DEPTH; g++)
        begin : g_entry
            always_ff @(posedge aclk)
            begin
                if (wr_en && wr_idx == elb_idx_t'(g))
                begin
                    mem_q[g] <= wr_data;
                end
            end
        end
    endgenerate

    // indices stay below the active capacity, never past the array
    assign rd_data_a = mem_q[rd_idx_a];
    assign rd_data_b = mem_q[rd_idx_b];
endmodule

//--- rtl/elb_event_log.sv
// circular event log with AXI4-Lite access and local panel browsing
`timescale 1ns/100ps
module elb_event_log
    import elb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic evt_valid,
    input wire logic [7:0] evt_stage,
    input wire elb_kind_e evt_kind,
    input wire elb_stamp_s evt_stamp,
    input wire logic [15:0] evt_fault_pu,
    input wire logic [15:0] evt_fault_pri,
    input wire logic panel_fwd_btn,
    input wire logic panel_back_btn,
    output elb_entry_s panel_entry,
    output logic panel_valid,
    output logic popup_active,
    output logic irq
);
    function automatic elb_idx_t wrap_add(elb_idx_t a, elb_idx_t b, elb_idx_t cap);
        logic [ELB_IW:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= {1'b0, cap})
        begin
            s = s - {1'b0, cap};
        end
        return s[ELB_IW-1:0];
    endfunction

    function automatic logic [31:0] strb_merge(logic [31:0] old, logic [31:0] nw,
                                               logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // channel in the upper byte, number below
    function automatic logic [31:0] code_word(elb_entry_s e, logic present);
        return {present, 13'h0, e.overflow_marker, e.fault_value_scaling,
                e.event_channel_number, e.channel_event_number};
    endfunction

    // bus slave state
    logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q, rdata_q;
    logic [3:0] w_strb_q;
    // log state
    logic [2:0] ctrl_q;
    elb_idx_t cap_q, head_q, count_q, rd_q, unread_q, panel_pos_q;
    logic [31:0] mask_q;
    logic [1:0] status_q, ien_q;
    elb_entry_s held_q, panel_entry_q;
    logic held_v_q, panel_valid_q, popup_q, irq_q;
    logic [1:0] btn_s1_q, btn_s2_q, btn_s3_q;

    // write channel handshakes
    wire aw_take = awvalid && awready_q;
    wire w_take = wvalid && wready_q;
    wire wr_do = aw_have_q && w_have_q && !bvalid_q;
    wire aw_have_d = (aw_have_q && !wr_do) || aw_take;
    wire w_have_d = (w_have_q && !wr_do) || w_take;
    wire bvalid_d = wr_do || (bvalid_q && !bready);
    wire [7:0] wr_ofs = {aw_addr_q[7:2], 2'b00};
    wire wr_ctrl = wr_do && wr_ofs == ELB_CTRL_OFS;
    wire wr_cap = wr_do && wr_ofs == ELB_CAP_OFS;
    wire wr_mask = wr_do && wr_ofs == ELB_MASK_OFS;
    wire wr_stat = wr_do && wr_ofs == ELB_STAT_OFS;
    wire wr_ien = wr_do && wr_ofs == ELB_IEN_OFS;
    wire wr_ok = wr_ctrl || wr_cap || wr_mask || wr_stat || wr_ien;
    wire [31:0] ctrl_m = strb_merge({29'h0, ctrl_q}, w_data_q, w_strb_q);
    wire [31:0] mask_m = strb_merge(mask_q, w_data_q, w_strb_q);
    wire [31:0] cap_m = strb_merge({21'h0, cap_q}, w_data_q, w_strb_q);
    wire [31:0] w1c_m = strb_merge(32'h0, w_data_q, w_strb_q);
    wire [31:0] ien_m = strb_merge({30'h0, ien_q}, w_data_q, w_strb_q);
    // out-of-range sizes clamp to the nearest limit
    wire elb_idx_t cap_wr_val = (cap_m < {21'h0, ELB_CAP_MIN}) ? ELB_CAP_MIN :
                                (cap_m > {21'h0, ELB_CAP_MAX}) ? ELB_CAP_MAX : cap_m[10:0];
    // a resize also clears, since old indices lose meaning
    wire clr_now = wr_cap || (wr_ctrl && ctrl_m[ELB_CTRL_CLEAR]);

    // read channel
    wire ar_take = arvalid && arready_q;
    wire rvalid_d = ar_take || (rvalid_q && !rready);
    wire [7:0] rd_ofs = {araddr[7:2], 2'b00};
    wire rd_pop = ar_take && rd_ofs == ELB_POP_OFS;

    // event intake
    // mask bit per stage 0 to 7 and transition, set means drop; higher stages are never masked
    wire evt_masked = (evt_stage < ELB_MASKED_STAGES) && mask_q[{evt_stage[2:0], evt_kind}];
    wire do_log = evt_valid && !evt_masked && !clr_now;
    wire full = count_q == cap_q;
    wire do_pop = rd_pop && unread_q != 11'h000 && !clr_now;
    // oldest overwritten while still unread means loss
    wire lost = do_log && full && unread_q == count_q && !do_pop;
    // when full the oldest slot takes the new entry
    wire elb_idx_t wr_idx = full ? head_q : wrap_add(head_q, count_q, cap_q);
    elb_entry_s new_entry, pop_entry, panel_rd;
    always_comb
    begin
        // code, date, time and fault value stored together
        new_entry.overflow_marker = lost;
        new_entry.fault_value_scaling = ctrl_q[ELB_CTRL_SCALE];
        // stage selects channel, transition selects number
        new_entry.event_channel_number = evt_stage;
        new_entry.channel_event_number = {6'h00, evt_kind};
        // millisecond field kept as the source quantised it
        new_entry.stamp = evt_stamp;
        // scale chosen at logging time and recorded
        new_entry.fault = (ctrl_q[ELB_CTRL_SCALE] == per_unit_scale) ? evt_fault_pu
                                                                      : evt_fault_pri;
    end

    // newest-first counts back from the newest slot
    // empty log would wrap below zero and index past the store
    wire panel_rev = ctrl_q[ELB_CTRL_ORDER] && count_q != 11'h000;
    wire elb_idx_t panel_ofs = panel_rev ? (count_q - 11'h001 - panel_pos_q) : panel_pos_q;
    wire elb_idx_t panel_idx = wrap_add(head_q, panel_ofs, cap_q);

    elb_entry_mem u_mem
    (
        .aclk(aclk),
        .wr_en(do_log),
        .wr_idx(wr_idx),
        .wr_data(new_entry),
        .rd_idx_a(rd_q),
        .rd_data_a(pop_entry),
        .rd_idx_b(panel_idx),
        .rd_data_b(panel_rd)
    );

    // register read decode
    wire [31:0] pop_word = (unread_q != 11'h000) ? code_word(pop_entry, 1'b1) : 32'h0;
    wire rd_known = rd_ofs inside {ELB_CTRL_OFS, ELB_CAP_OFS, ELB_COUNT_OFS, ELB_MASK_OFS,
                                   ELB_POP_OFS, ELB_HCODE_OFS, ELB_HDATE_OFS, ELB_HTIME_OFS,
                                   ELB_HFAULT_OFS, ELB_STAT_OFS, ELB_IEN_OFS, ELB_UNREAD_OFS};
    wire [31:0] rd_word =
        (rd_ofs == ELB_CTRL_OFS) ? {29'h0, ctrl_q} :
        (rd_ofs == ELB_CAP_OFS) ? {21'h0, cap_q} :
        (rd_ofs == ELB_COUNT_OFS) ? {21'h0, count_q} :
        (rd_ofs == ELB_MASK_OFS) ? mask_q :
        (rd_ofs == ELB_POP_OFS) ? pop_word :
        // held copy answers repeats without touching the pointer
        (rd_ofs == ELB_HCODE_OFS) ? code_word(held_q, held_v_q) :
        (rd_ofs == ELB_HDATE_OFS) ? {11'h0, held_q.stamp[47:27]} :
        (rd_ofs == ELB_HTIME_OFS) ? {5'h0, held_q.stamp[26:0]} :
        (rd_ofs == ELB_HFAULT_OFS) ? {16'h0, held_q.fault} :
        (rd_ofs == ELB_STAT_OFS) ? {30'h0, status_q} :
        (rd_ofs == ELB_IEN_OFS) ? {30'h0, ien_q} :
        (rd_ofs == ELB_UNREAD_OFS) ? {21'h0, unread_q} : 32'h0;

    // panel buttons come from pins
    wire fwd_edge = btn_s2_q[0] && !btn_s3_q[0];
    wire back_edge = btn_s2_q[1] && !btn_s3_q[1];
    wire elb_idx_t count_d = clr_now ? 11'h000 : count_q + {10'h000, do_log && !full};
    wire elb_idx_t unread_d = clr_now ? 11'h000 :
        unread_q + {10'h000, do_log} - {10'h000, do_pop} - {10'h000, lost};
    wire [1:0] stat_set = {lost, do_log};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= ELB_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= ELB_RESP_OKAY;
            rdata_q <= 32'h0;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            // one write at a time: no new address until the response is gone
            awready_q <= !aw_have_d && !bvalid_d;
            wready_q <= !w_have_d && !bvalid_d;
            bvalid_q <= bvalid_d;
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (wr_do)
            begin
                bresp_q <= wr_ok ? ELB_RESP_OKAY : ELB_RESP_SLVERR;
            end
            if (ar_take)
            begin
                rdata_q <= rd_word;
                rresp_q <= rd_known ? ELB_RESP_OKAY : ELB_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (aw_take)
        begin
            aw_addr_q <= awaddr;
        end
        if (w_take)
        begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= ELB_CTRL_RST;
            cap_q <= ELB_CAP_DEF;
            mask_q <= ELB_MASK_RST;
            ien_q <= ELB_STAT_RST;
            status_q <= ELB_STAT_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= wr_ctrl ? ctrl_m[2:0] : ctrl_q;
            cap_q <= wr_cap ? cap_wr_val : cap_q;
            mask_q <= wr_mask ? mask_m : mask_q;
            ien_q <= wr_ien ? ien_m[1:0] : ien_q;
            // a new event wins over a clear in the same cycle
            status_q <= (status_q & ~(wr_stat ? w1c_m[1:0] : 2'h0)) | stat_set;
            irq_q <= |(((status_q & ~(wr_stat ? w1c_m[1:0] : 2'h0)) | stat_set) & ien_q);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || clr_now)
        begin
            // empty log, nothing left to report
            head_q <= 11'h000;
            count_q <= 11'h000;
            rd_q <= 11'h000;
            unread_q <= 11'h000;
            held_v_q <= 1'b0;
        end
        else
        begin
            head_q <= (do_log && full) ? wrap_add(head_q, 11'h001, cap_q) : head_q;
            count_q <= count_d;
            unread_q <= unread_d;
            // each pop moves on to the next unread entry
            rd_q <= (do_pop || lost) ? wrap_add(rd_q, 11'h001, cap_q) : rd_q;
            held_v_q <= held_v_q || do_pop;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (do_pop)
        begin
            held_q <= pop_entry;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            btn_s1_q <= 2'h0;
            btn_s2_q <= 2'h0;
            btn_s3_q <= 2'h0;
            panel_pos_q <= 11'h000;
            panel_valid_q <= 1'b0;
            popup_q <= 1'b0;
        end
        else
        begin
            btn_s1_q <= {panel_back_btn, panel_fwd_btn};
            btn_s2_q <= btn_s1_q;
            btn_s3_q <= btn_s2_q;
            // cursor saturates at both ends of the stored range
            if (clr_now)
            begin
                panel_pos_q <= 11'h000;
            end
            else if (fwd_edge && panel_pos_q + 11'h001 < count_q)
            begin
                panel_pos_q <= panel_pos_q + 11'h001;
            end
            else if (back_edge && panel_pos_q != 11'h000)
            begin
                panel_pos_q <= panel_pos_q - 11'h001;
            end
            panel_valid_q <= count_q != 11'h000;
            // any panel key dismisses the pop-up
            popup_q <= (do_log && ctrl_q[ELB_CTRL_POPUP]) || (popup_q && !fwd_edge && !back_edge);
        end
    end

    always_ff @(posedge aclk)
    begin
        panel_entry_q <= panel_rd;
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;
    assign panel_entry = panel_entry_q;
    assign panel_valid = panel_valid_q;
    assign popup_active = popup_q;
    assign irq = irq_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_clear_req;
        wr_ctrl && ctrl_m[ELB_CTRL_CLEAR];
    endsequence
    sequence s_reread;
        ar_take && rd_ofs == ELB_HCODE_OFS && !lost && !clr_now;
    endsequence

    mask_drop_a: assert property (
        evt_valid && evt_masked && !do_pop && !clr_now |=> $stable(count_q) && $stable(unread_q))
        else $error("masked event reached the log");
    cap_range_a: assert property (
        cap_q >= ELB_CAP_MIN && cap_q <= ELB_CAP_MAX)
        else $error("capacity outside its range");
    full_wrap_a: assert property (
        do_log && full && !clr_now |=> count_q == $past(count_q) && head_q != $past(head_q))
        else $error("full log did not overwrite the oldest entry");
    pop_adv_a: assert property (
        do_pop |=> rd_q != $past(rd_q) && unread_q == $past(unread_d) && rdata_q[31])
        else $error("pop did not advance the read pointer");
    reread_hold_a: assert property (
        s_reread |=> $stable(rd_q) && rdata_q == code_word(held_q, held_v_q))
        else $error("re-read moved the read pointer");
    ovf_mark_a: assert property (
        lost |=> unread_q == $past(unread_q) && status_q[ELB_ST_OVF])
        else $error("lost entry not flagged");
    clear_empty_a: assert property (
        s_clear_req |=> count_q == 11'h000 && unread_q == 11'h000 && !held_v_q)
        else $error("clear left entries behind");
    popup_show_a: assert property (
        do_log && ctrl_q[ELB_CTRL_POPUP] |=> popup_active)
        else $error("pop-up missing after logged event");
    panel_step_a: assert property (
        fwd_edge && !clr_now && panel_pos_q + 11'h001 < count_q && !do_pop
        |=> panel_pos_q == $past(panel_pos_q) + 11'h001 && ($stable(unread_q) || $past(do_log)))
        else $error("panel step wrong or touched the reader");
endmodule

//--- verif/elb_reader_model.sv
// partner model: supervisory reader, an AXI4-Lite master polling the log
`timescale 1ns/100ps
module elb_reader_model
(
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    output logic bus_timeout
);
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, bus_timeout} = '0;
    end
    // sampled at the fall, which holds what the next rise sees
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'b111;
        repeat (50)
        begin
            @(negedge aclk);
            {ta, tw, tb, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
            @(posedge aclk);
            // released payload inverted so a stale value cannot pass
            if (ta)
                {awvalid, awaddr} <= {1'b0, ~awaddr};
            if (tw)
                {wvalid, wdata} <= {1'b0, ~wdata};
            if (tb)
            begin
                bready <= 1'b0;
                return;
            end
        end
        bus_timeout <= 1'b1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        repeat (50)
        begin
            @(negedge aclk);
            {ta, tr, d, r} = {arvalid & arready, rvalid, rdata, rresp};
            @(posedge aclk);
            if (ta)
                {arvalid, araddr} <= {1'b0, ~araddr};
            if (tr)
            begin
                rready <= 1'b0;
                return;
            end
        end
        bus_timeout <= 1'b1;
    endtask
endmodule

//--- verif/test_event_log_buffer.sv
// self-checking bench of the event log buffer
`timescale 1ns/100ps
module test_event_log_buffer
    import elb_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic evt_valid = 1'b0;
    logic panel_fwd_btn = 1'b0;
    logic panel_back_btn = 1'b0;
    logic [7:0] evt_stage = 8'h00;
    elb_kind_e evt_kind = ELB_START_ON;
    elb_stamp_s evt_stamp = '0;
    logic [15:0] evt_fault_pu = 16'h001B;
    logic [15:0] evt_fault_pri = 16'h0AB0;
    elb_entry_s panel_entry;
    logic panel_valid, popup_active, irq, bus_timeout;
    int mismatches = 0;
    int checked = 0;
    always #5 aclk = ~aclk;
    elb_event_log u_elb_event_log (.*);
    elb_reader_model u_elb_reader_model (.*);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge bus_timeout)
    begin
        mismatches++;
        finish_test();
    end
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        u_elb_reader_model.wr(a, d, r);
        chk("bresp", 32'h0, 32'(r));
    endtask
    task automatic peek(input logic [7:0] a);
        u_elb_reader_model.rd(a, v, r);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        peek(a);
        chk("rresp", 32'h0, 32'(r));
        chk($sformatf("reg %h", a), e, v);
    endtask
    task automatic evt(input logic [7:0] s, input elb_kind_e k, input logic [9:0] ms);
        @(posedge aclk);
        {evt_valid, evt_stage, evt_kind} <= {1'b1, s, k};
        evt_stamp <= {12'h7D7, 4'h1, 5'h1F, 5'h08, 6'h23, 6'h0D, ms};
        @(posedge aclk);
        evt_valid <= 1'b0;
    endtask
    // key held past the synchroniser, result settled by the final fall
    task automatic press(input logic fwd);
        @(posedge aclk);
        {panel_fwd_btn, panel_back_btn} <= {fwd, !fwd};
        repeat (4) @(posedge aclk);
        {panel_fwd_btn, panel_back_btn} <= 2'b00;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic t_reset();
        logic [7:0] z [7] = '{ELB_CTRL_OFS, ELB_COUNT_OFS, ELB_MASK_OFS, ELB_POP_OFS,
            ELB_STAT_OFS, ELB_IEN_OFS, ELB_UNREAD_OFS};
        foreach (z[i])
            rreg(z[i], 32'h0);
        rreg(ELB_CAP_OFS, 32'h0C8);
        peek(8'h30);
        chk("unmapped rresp", 32'(ELB_RESP_SLVERR), 32'(r));
        chk("unmapped rdata", 32'h0, v);
        u_elb_reader_model.wr(ELB_COUNT_OFS, 32'h5, r);
        chk("read-only bresp", 32'(ELB_RESP_SLVERR), 32'(r));
        wreg(ELB_CAP_OFS, 32'h28);
        rreg(ELB_CAP_OFS, 32'h32);
        wreg(ELB_CAP_OFS, 32'h7D1);
        rreg(ELB_CAP_OFS, 32'h7D0);
    endtask
    task automatic t_log();
        logic [7:0] nums [4];
        wreg(ELB_IEN_OFS, 32'h1);
        for (int k = 0; k < 4; k++)
            evt(8'h01, elb_kind_e'(k), 10'h19D);
        rreg(ELB_COUNT_OFS, 32'h4);
        @(negedge aclk);
        chk("irq raised", 32'h1, 32'(irq));
        for (int k = 0; k < 4; k++)
        begin
            peek(ELB_POP_OFS);
            chk("pop present", 32'h1, 32'(v[31]));
            chk("pop channel", 32'h1, 32'(v[15:8]));
            nums[k] = v[7:0];
            if (k == 2)
            begin
                rreg(ELB_HCODE_OFS, v);
                rreg(ELB_HCODE_OFS, v);
                rreg(ELB_UNREAD_OFS, 32'h1);
            end
        end
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < i; j++)
                chk("code distinct", 32'h1, 32'(nums[i] !== nums[j]));
        rreg(ELB_HDATE_OFS, {11'h0, 12'h7D7, 4'h1, 5'h1F});
        rreg(ELB_HTIME_OFS, {5'h0, 5'h08, 6'h23, 6'h0D, 10'h19D});
        peek(ELB_HFAULT_OFS);
        chk("fault per unit", 32'h001B, 32'(v[15:0]));
        rreg(ELB_POP_OFS, 32'h0);
        wreg(ELB_STAT_OFS, 32'h1);
        @(negedge aclk);
        chk("irq cleared", 32'h0, 32'(irq));
        wreg(ELB_IEN_OFS, 32'h0);
        evt(8'h01, ELB_TRIP_ON, 10'h001);
        rreg(ELB_STAT_OFS, 32'h1);
        @(negedge aclk);
        chk("irq masked", 32'h0, 32'(irq));
    endtask
    task automatic t_clear();
        wreg(ELB_CTRL_OFS, 32'h8);
        rreg(ELB_CTRL_OFS, 32'h0);
        rreg(ELB_COUNT_OFS, 32'h0);
        rreg(ELB_UNREAD_OFS, 32'h0);
        rreg(ELB_POP_OFS, 32'h0);
        @(negedge aclk);
        chk("panel empty", 32'h0, 32'(panel_valid));
    endtask
    task automatic t_mask();
        wreg(ELB_MASK_OFS, 32'h400);
        evt(8'h02, ELB_TRIP_ON, 10'h002);
        rreg(ELB_COUNT_OFS, 32'h0);
        evt(8'h02, ELB_TRIP_OFF, 10'h003);
        rreg(ELB_COUNT_OFS, 32'h1);
        wreg(ELB_CTRL_OFS, 32'h2);
        evt(8'h03, ELB_START_ON, 10'h004);
        peek(ELB_POP_OFS);
        chk("pop unmasked", 32'h2, 32'(v[15:8]));
        peek(ELB_POP_OFS);
        chk("pop scale flag", 32'h1, 32'(v[16]));
        peek(ELB_HFAULT_OFS);
        chk("fault primary", 32'h0AB0, 32'(v[15:0]));
    endtask
    task automatic t_popup();
        wreg(ELB_CTRL_OFS, 32'h4);
        evt(8'h01, ELB_START_OFF, 10'h005);
        repeat (2) @(negedge aclk);
        chk("popup shown", 32'h1, 32'(popup_active));
        press(1'b1);
        chk("popup dismissed", 32'h0, 32'(popup_active));
        wreg(ELB_CTRL_OFS, 32'h0);
        evt(8'h01, ELB_START_OFF, 10'h006);
        repeat (2) @(negedge aclk);
        chk("popup disabled", 32'h0, 32'(popup_active));
    endtask
    task automatic t_overflow();
        wreg(ELB_CAP_OFS, 32'h32);
        for (int i = 0; i <= 50; i++)
            evt(8'h01, ELB_START_ON, 10'(i));
        rreg(ELB_COUNT_OFS, 32'h32);
        peek(ELB_STAT_OFS);
        chk("overflow status", 32'h1, 32'(v[1]));
        for (int j = 1; j <= 50; j++)
        begin
            peek(ELB_POP_OFS);
            chk("overflow mark", 32'(j == 50), 32'(v[17]));
            if (j == 1)
                rreg(ELB_HTIME_OFS, {5'h0, 5'h08, 6'h23, 6'h0D, 10'h001});
        end
        rreg(ELB_POP_OFS, 32'h0);
        press(1'b0);
        press(1'b0);
        chk("panel oldest", 32'h1, 32'(panel_entry.stamp.msec));
        chk("panel valid", 32'h1, 32'(panel_valid));
        press(1'b1);
        chk("panel forward", 32'h2, 32'(panel_entry.stamp.msec));
        wreg(ELB_CTRL_OFS, 32'h1);
        press(1'b0);
        chk("panel newest", 32'h32, 32'(panel_entry.stamp.msec));
        chk("panel overflow", 32'h1, 32'(panel_entry.overflow_marker));
    endtask
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_log();
        t_clear();
        t_mask();
        t_popup();
        t_overflow();
        finish_test();
    end
endmodule
